// ### rtl/rx_frontend_ctrl.sv
// Receiver front-end control: input routing, filters, gain, level capture
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module rx_frontend_ctrl
  import rx_frontend_pkg::*;
(
  input  wire logic                         CLK,
  input  wire logic                         RESET,
  input  wire logic                         CE,
  // APB slave
  input  wire rx_frontend_pkg::apb_req_t    APB_REQ,
  output logic [rx_frontend_pkg::DATA_W-1:0] PRDATA,
  output logic                              PREADY,
  output logic                              PSLVERR,
  // Digitized envelopes from the two antenna inputs
  input  wire logic                         FIRST_RF_INPUT,
  input  wire logic                         SECOND_RF_INPUT,
  // Peak level codes measured on each receiver path
  input  wire logic [rx_frontend_pkg::LEVEL_W-1:0] MAIN_PATH_LEVEL,
  input  wire logic [rx_frontend_pkg::LEVEL_W-1:0] AUX_PATH_LEVEL,
  // Frame framing from the digital receiver, same clock
  input  wire logic                         RX_FRAME_START,
  input  wire logic                         RX_FRAME_END,
  // Routed receiver paths
  output logic                              MAIN_RX,
  output logic                              AUX_RX,
  output logic                              DIGITIZER_IN,
  // Analog controls
  output logic [rx_frontend_pkg::BAND_W-1:0] BAND_SELECT,
  output logic                              DEFAULT_BAND,
  output logic                              HIGH_RATE_GAIN_CUT,
  output logic [1:0]                        DIGITIZER_GAIN_CUT,
  output logic                              AGC_THRESHOLD_LOW,
  output logic [rx_frontend_pkg::LEVEL_W-1:0] AGC_REDUCTION,
  output logic                              AGC_FROZEN
);

  // ==========================================================
  // Declarations
  localparam int SYNC_W = 2 + 2 * LEVEL_W;

  // Register images
  logic [REG_W-1:0]  chip_status;
  logic [REG_W-1:0]  protocol;
  logic [REG_W-1:0]  tuning;
  level_pair_t       level_store;

  // Synchroniser lanes
  logic [SYNC_W-1:0] pin_raw;
  logic [SYNC_W-1:0] sync_a;
  logic [SYNC_W-1:0] sync_b;
  logic [SYNC_W-1:0] sync_c;
  logic [SYNC_W-1:0] pin_clean;

  // Clean input views
  logic              first_in;
  logic              second_in;
  logic [LEVEL_W-1:0] main_level;
  logic [LEVEL_W-1:0] aux_level;

  // Register field views
  logic              swap;
  logic              agc_enable;
  logic              freeze_off;
  logic              thr_low;
  logic [1:0]        gain_cut;
  logic [BAND_W-1:0] band_bits;

  // Routing and gain links
  logic              main_sel;
  logic              aux_sel;
  logic [LEVEL_W:0]  threshold;
  logic              level_high;
  logic [LEVEL_W-1:0] agc_level;
  logic              agc_hold;

  // Bus decode
  logic              setup;
  logic              access;
  logic              wr_en;
  logic [9:0]        reg_index;
  logic              addr_ok;
  logic              hit_status;
  logic              hit_protocol;
  logic              hit_tuning;
  logic              hit_level;
  logic [REG_W-1:0]  wdata;
  logic [REG_W-1:0]  next_rdata;
  logic              next_err;
  logic              err;

  // ==========================================================
  // Preset lookup: protocol code to default tuning byte
  // Unknown codes give the default band
  function automatic logic [REG_W-1:0] preset_for(input logic [3:0] code);
    logic [REG_W-1:0] value;
    value = PRESET_OTHER;
    unique case (code)
      PROTO_A_106: value = PRESET_A_106;
      PROTO_B_848: value = PRESET_B_848;
      PROTO_F_212: value = PRESET_F_212;
      default:     value = PRESET_OTHER;
    endcase
    return value;
  endfunction : preset_for

  // ==========================================================
  // Pin synchronisers
  // Pins and level codes come from the analog side, so each bit passes
  // three flops; the clean value only moves when the last two agree.
  // A multi-bit level code can still be caught mid-change for one
  // cycle; levels are peak-held, so the next agreeing sample is right.
  // The agreement stage also drops one-cycle glitches.
  assign pin_raw = {AUX_PATH_LEVEL, MAIN_PATH_LEVEL, SECOND_RF_INPUT, FIRST_RF_INPUT};

  generate
    for (genvar i = 0; i < SYNC_W; i++)
    begin : g_sync
      // Stage chain; first stage feeds only the second
      always_ff @(posedge CLK)
      begin
        if (RESET)
        begin
          sync_a[i] <= 1'b0;
          sync_b[i] <= 1'b0;
          sync_c[i] <= 1'b0;
        end
        else if (CE)
        begin
          sync_a[i] <= pin_raw[i];
          sync_b[i] <= sync_a[i];
          sync_c[i] <= sync_b[i];
        end
      end

      // Agreement filter
      // Holds while the stages differ
      always_ff @(posedge CLK)
      begin
        if (RESET)
          pin_clean[i] <= 1'b0;
        else if (CE && sync_b[i] == sync_c[i])
          pin_clean[i] <= sync_c[i];
      end
    end
  endgenerate

  // Lane order follows pin_raw
  assign first_in   = pin_clean[0];
  assign second_in  = pin_clean[1];
  assign main_level = pin_clean[2 +: LEVEL_W];
  assign aux_level  = pin_clean[2 + LEVEL_W +: LEVEL_W];

  // ==========================================================
  // Register fields
  // Fixed positions from the package
  assign swap       = chip_status[CS_SWAP_BIT];
  assign agc_enable = chip_status[CS_AGC_EN_BIT];
  assign freeze_off = tuning[TUNE_FREEZE_BIT];
  assign thr_low    = tuning[TUNE_THR_BIT];
  assign gain_cut   = tuning[TUNE_GAIN_LSB +: 2];
  assign band_bits  = tuning[TUNE_BAND_LSB +: BAND_W];

  // ==========================================================
  // APB decode
  // Zero wait states: the access phase always completes
  assign setup     = APB_REQ.psel && !APB_REQ.penable;
  assign access    = APB_REQ.psel && APB_REQ.penable;
  assign reg_index = APB_REQ.paddr[ADDR_W-1:2];
  assign addr_ok   = (APB_REQ.paddr[1:0] == 2'b00);
  assign wdata     = APB_REQ.pwdata[REG_W-1:0];

  // Misaligned addresses hit nothing
  assign hit_status   = addr_ok && reg_index == IDX_CHIP_STATUS;
  assign hit_protocol = addr_ok && reg_index == IDX_PROTOCOL;
  assign hit_tuning   = addr_ok && reg_index == IDX_TUNING;
  assign hit_level    = addr_ok && reg_index == IDX_LEVEL;

  // Writes land only at the completing edge; level register is read-only
  // CE low drops writes; PREADY still answers
  assign wr_en = access && APB_REQ.pwrite && CE;

  // Read mux, unmapped addresses answer zero with an error
  always_comb
  begin
    next_rdata = '0;
    next_err   = 1'b0;
    if (hit_status)
      next_rdata = chip_status;
    else if (hit_protocol)
      next_rdata = protocol;
    else if (hit_tuning)
      next_rdata = tuning;
    else if (hit_level)
    begin
      next_rdata = {2'b00, level_store};
      // Read-only: writes here are refused
      next_err   = APB_REQ.pwrite;
    end
    else
      next_err = 1'b1;
  end

  // Answer registered in the setup cycle, presented in the access cycle
  // Write transfers read back zero
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      PRDATA <= '0;
      err    <= 1'b0;
    end
    else if (CE && setup)
    begin
      PRDATA <= APB_REQ.pwrite ? '0 : {{(DATA_W-REG_W){1'b0}}, next_rdata};
      err    <= next_err;
    end
  end

  // Handshake outputs are combinational
  assign PREADY  = access;
  assign PSLVERR = access && err;

  // ==========================================================
  // Chip status: swap and gain control enable clear at reset
  // Other bits are stored but unused here
  always_ff @(posedge CLK)
  begin
    if (RESET)
      chip_status <= CS_RESET;
    else if (wr_en && hit_status)
      chip_status <= wdata;
  end

  // Protocol selection
  // Low nibble picks the preset
  always_ff @(posedge CLK)
  begin
    if (RESET)
      protocol <= PROTO_RESET;
    else if (wr_en && hit_protocol)
      protocol <= wdata;
  end

  // Tuning: a protocol write reloads the preset, a later direct
  // write overrides it, so fine-tuning must follow the protocol write
  always_ff @(posedge CLK)
  begin
    if (RESET)
      tuning <= TUNING_RESET;
    else if (wr_en && hit_protocol)
      tuning <= preset_for(wdata[3:0]);
    else if (wr_en && hit_tuning)
      tuning <= wdata;
  end

  // ==========================================================
  // Level capture
  // Both paths are latched together when a response ends, so software
  // always compares a matched pair when choosing the routing
  // Not cleared by a read
  always_ff @(posedge CLK)
  begin
    if (RESET)
      level_store <= '0;
    else if (CE && RX_FRAME_END)
      level_store <= '{aux_lvl: aux_level, main_lvl: main_level};
  end

  // ==========================================================
  // Input routing
  // Swap moves both paths at one edge
  assign main_sel = swap ? second_in : first_in;
  assign aux_sel  = swap ? first_in : second_in;

  // Routed paths registered; the digitizer sees only the main path
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      MAIN_RX      <= 1'b0;
      AUX_RX       <= 1'b0;
      DIGITIZER_IN <= 1'b0;
    end
    else if (CE)
    begin
      MAIN_RX      <= main_sel;
      AUX_RX       <= aux_sel;
      DIGITIZER_IN <= main_sel;
    end
  end

  // ==========================================================
  // Gain control threshold
  // Threshold sits at a multiple of the minimum digitizing level, which
  // itself moves up with the digitizer reduction step
  // A level equal to the threshold counts
  assign threshold  = (thr_low ? THR_3X : THR_5X) + {2'b00, gain_cut};
  assign level_high = {1'b0, main_level} >= threshold;


  // Edges counted on the routed main path
  agc_tracker u_agc
  (
    .clk         (CLK),
    .reset       (RESET),
    .ce          (CE),
    .enable      (agc_enable),
    .freeze_off  (freeze_off),
    .frame_start (RX_FRAME_START),
    .subcarrier  (main_sel),
    .level_high  (level_high),
    .reduction   (agc_level),
    .frozen      (agc_hold)
  );

  // ==========================================================
  // Analog control outputs
  // Registered, so no decode glitch reaches the analog side
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      BAND_SELECT        <= '0;
      DEFAULT_BAND       <= 1'b1;
      HIGH_RATE_GAIN_CUT <= 1'b0;
      DIGITIZER_GAIN_CUT <= 2'b00;
      AGC_THRESHOLD_LOW  <= 1'b0;
      AGC_REDUCTION      <= '0;
      AGC_FROZEN         <= 1'b0;
    end
    else if (CE)
    begin
      BAND_SELECT        <= band_bits;
      DEFAULT_BAND       <= (band_bits == '0);
      HIGH_RATE_GAIN_CUT <= band_bits[BAND_HIGH_RATE];
      DIGITIZER_GAIN_CUT <= gain_cut;
      AGC_THRESHOLD_LOW  <= thr_low;
      AGC_REDUCTION      <= agc_level;
      AGC_FROZEN         <= agc_hold;
    end
  end

endmodule : rx_frontend_ctrl
`default_nettype wire

// ### rtl/rx_frontend_pkg.sv
// Constants, types and field layout for the receiver front-end control
//
// Operation
// - By default first input feeds main receiver, second feeds auxiliary.
// - Swap bit set: first input to auxiliary, second input to main.
// - Only main path drives the digitizer; auxiliary path only monitors level.
// - Capture main and auxiliary levels of a response together in level register.
// - Gain control loop runs only while its enable bit is one.
// - Active loop watches input level, adds reduction when at or above threshold.
// - Without override, gain freezes after 16 subcarrier edges for the packet.
// - Override bit set keeps gain control active for whole reception.
// - Gain reduction only increases during its enable period, tracking the peak.
// - Accumulated gain reduction clears at every receive frame start.
// - Protocol write loads filter presets; software may then fine-tune.
// - Tuning bits 7 to 4 choose the four pass bands.
// - Highest-rate band bit also lowers receive gain by seven decibels.
// - All band bits zero selects default band 240 kHz to 1.4 MHz.
// - Tuning bits 3:2 set digitizer reduction: none, 5, 10, 15 dB.
// - Tuning bit 1 picks threshold: five or three times minimum level.
package rx_frontend_pkg;

  // ==========================================================
  // Bus and register map
  localparam int          ADDR_W          = 12;
  localparam int          DATA_W          = 32;
  localparam int          REG_W           = 8;
  localparam logic [9:0]  IDX_CHIP_STATUS = 10'h000;
  localparam logic [9:0]  IDX_PROTOCOL    = 10'h001;
  localparam logic [9:0]  IDX_TUNING      = 10'h00a;
  localparam logic [9:0]  IDX_LEVEL       = 10'h00f;

  // ==========================================================
  // Field positions
  localparam int CS_AGC_EN_BIT   = 2;
  localparam int CS_SWAP_BIT     = 3;
  localparam int TUNE_FREEZE_BIT = 0;
  localparam int TUNE_THR_BIT    = 1;
  localparam int TUNE_GAIN_LSB   = 2;
  localparam int TUNE_BAND_LSB   = 4;
  localparam int BAND_HIGH_RATE  = 0;
  localparam int BAND_W          = 4;
  localparam int LEVEL_W         = 3;

  // ==========================================================
  // Reset values
  localparam logic [REG_W-1:0] CS_RESET     = 8'h00;
  localparam logic [REG_W-1:0] PROTO_RESET  = 8'h00;
  localparam logic [REG_W-1:0] TUNING_RESET = 8'h00;

  // ==========================================================
  // Gain control figures
  localparam logic [4:0]         FREEZE_EDGES = 5'h10;
  localparam logic [LEVEL_W:0]   THR_5X       = 4'h5;
  localparam logic [LEVEL_W:0]   THR_3X       = 4'h3;
  localparam logic [LEVEL_W-1:0] AGC_MAX      = 3'h7;

  // ==========================================================
  // Protocol codes and their tuning presets
  localparam logic [3:0]       PROTO_A_106   = 4'h8;
  localparam logic [3:0]       PROTO_B_848   = 4'hf;
  localparam logic [3:0]       PROTO_F_212   = 4'ha;
  localparam logic [REG_W-1:0] PRESET_A_106  = 8'h20;
  localparam logic [REG_W-1:0] PRESET_B_848  = 8'h10;
  localparam logic [REG_W-1:0] PRESET_F_212  = 8'h80;
  localparam logic [REG_W-1:0] PRESET_OTHER  = 8'h00;

  // ==========================================================
  // Types
  typedef struct packed {
    logic [ADDR_W-1:0] paddr;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [DATA_W-1:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [LEVEL_W-1:0] aux_lvl;
    logic [LEVEL_W-1:0] main_lvl;
  } level_pair_t;

  typedef enum logic [1:0] {
    AGC_IDLE  = 2'b00,
    AGC_TRACK = 2'b01,
    AGC_HOLD  = 2'b11
  } agc_state_t;

endpackage : rx_frontend_pkg

// ### rtl/agc_tracker.sv
// Gain control sequencer: peak tracking, freeze after subcarrier edges
`timescale 1ns/1ps
`default_nettype none
module agc_tracker
  import rx_frontend_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               reset,
  input  wire logic               ce,
  input  wire logic               enable,
  input  wire logic               freeze_off,
  input  wire logic               frame_start,
  input  wire logic               subcarrier,
  input  wire logic               level_high,
  output logic [LEVEL_W-1:0]      reduction,
  output logic                    frozen
);

  agc_state_t       state;
  logic [4:0]       edges;
  logic             sub_prev;
  logic             sub_edge;

  // Both edges of the subcarrier count
  assign sub_edge = subcarrier ^ sub_prev;
  assign frozen   = (state == AGC_HOLD);

  // ==========================================================
  // Sequencer
  always_ff @(posedge clk)
  begin
    if (reset)
      state <= AGC_IDLE;
    else if (ce)
    begin
      unique case (state)
        AGC_IDLE:
          if (enable)
            state <= AGC_TRACK;
        AGC_TRACK:
          if (!enable)
            state <= AGC_IDLE;
          else if (!freeze_off && sub_edge && edges == FREEZE_EDGES - 5'h1)
            state <= AGC_HOLD;
        AGC_HOLD:
          if (!enable)
            state <= AGC_IDLE;
          else if (frame_start || freeze_off)
            state <= AGC_TRACK;
      endcase
    end
  end

  // Edge counter restarts with each frame; saturates at the freeze count
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      edges    <= 5'h00;
      sub_prev <= 1'b0; // Idle level of the routed input, so no false edge
    end
    else if (ce)
    begin
      sub_prev <= subcarrier;
      if (frame_start)
        edges <= 5'h00;
      else if (sub_edge && edges != FREEZE_EDGES)
        edges <= edges + 5'h01;
    end
  end

  // Reduction only climbs while tracking; frame start wins over a step
  always_ff @(posedge clk)
  begin
    if (reset)
      reduction <= '0;
    else if (ce)
    begin
      if (frame_start || state == AGC_IDLE)
        reduction <= '0;
      else if (state == AGC_TRACK && level_high && reduction != AGC_MAX)
        reduction <= reduction + 3'h1;
    end
  end

endmodule : agc_tracker
`default_nettype wire

// ### sim/rx_frontend_checker.sv
// Port-level assertions for the receiver front-end control
`timescale 1ns/1ps
`default_nettype none
module rx_frontend_checker
(
  input  wire logic                                CLK,
  input  wire logic                                RESET,
  input  wire logic                                CE,
  input  wire rx_frontend_pkg::apb_req_t           APB_REQ,
  input  wire logic                                PREADY,
  input  wire logic                                PSLVERR,
  input  wire logic                                MAIN_RX,
  input  wire logic                                AUX_RX,
  input  wire logic                                DIGITIZER_IN,
  input  wire logic [rx_frontend_pkg::BAND_W-1:0]  BAND_SELECT,
  input  wire logic                                DEFAULT_BAND,
  input  wire logic                                HIGH_RATE_GAIN_CUT,
  input  wire logic                                RX_FRAME_START,
  input  wire logic [rx_frontend_pkg::LEVEL_W-1:0] AGC_REDUCTION,
  input  wire logic                                AGC_FROZEN
);
  import rx_frontend_pkg::*;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  // ==========================================================
  // Bus and decode relations
  a_ready_access: assert property (PREADY == (APB_REQ.psel && APB_REQ.penable)) else $error("pready off access");
  a_bad_align: assert property (PREADY && APB_REQ.paddr[1:0] != 2'b00 |-> PSLVERR) else $error("misaligned accepted");
  a_digit_main: assert property (DIGITIZER_IN == MAIN_RX) else $error("digitizer not on main");
  a_default_band: assert property (DEFAULT_BAND == (BAND_SELECT == 4'h0)) else $error("default band wrong");
  a_rate_cut: assert property (HIGH_RATE_GAIN_CUT == BAND_SELECT[BAND_HIGH_RATE]) else $error("rate cut wrong");
  // Values seen at the first edge after reset is released
  a_reset_state: assert property ($fell(RESET) |-> !MAIN_RX && !AUX_RX && AGC_REDUCTION == 3'h0 && DEFAULT_BAND)
    else $error("reset state wrong");
  // ==========================================================
  // Gain control; a decrease is only legal as a clear to zero
  a_gain_up_only: assert property (AGC_REDUCTION < $past(AGC_REDUCTION) |-> AGC_REDUCTION == 3'h0)
    else $error("reduction went back");
  a_gain_step: assert property (AGC_REDUCTION > $past(AGC_REDUCTION) |-> AGC_REDUCTION == $past(AGC_REDUCTION) + 3'h1)
    else $error("reduction step not one");
  a_frame_clear: assert property (RX_FRAME_START && CE |-> ##2 AGC_REDUCTION == 3'h0)
    else $error("frame start no clear");
  a_freeze_hold: assert property (AGC_FROZEN [*3] |-> $stable(AGC_REDUCTION)) else $error("frozen gain moved");
  c_swap_route: cover property (AUX_RX && !MAIN_RX);
  c_agc_full: cover property (AGC_REDUCTION == AGC_MAX);
  c_frozen: cover property ($rose(AGC_FROZEN));
  c_refused: cover property (PSLVERR && PREADY);
endmodule : rx_frontend_checker
`default_nettype wire

// ### sim/antenna_model.sv
// Antenna divider model: envelopes on both inputs and their level codes
`timescale 1ns/1ps
`default_nettype none
module antenna_model
(
  input  wire logic       clk,
  input  wire logic       tone,
  input  wire logic       idle1,
  input  wire logic       idle2,
  input  wire logic [2:0] main_code,
  input  wire logic [2:0] aux_code,
  output logic            rf1,
  output logic            rf2,
  output logic [2:0]      main_lvl,
  output logic [2:0]      aux_lvl
);
  logic [1:0] ph;
  // Known levels before the first edge
  initial
  begin
    ph = 2'b00;
    rf1 = 1'b0;
    rf2 = 1'b0;
    main_lvl = 3'h0;
    aux_lvl = 3'h0;
  end
  // Subcarrier edge every four cycles, so the input glitch filter never eats one
  always @(posedge clk)
  begin
    ph <= ph + 2'b01;
    if (!tone)
      rf1 <= idle1;
    else if (ph == 2'b11)
      rf1 <= !rf1;
    rf2 <= idle2;
    main_lvl <= main_code;
    aux_lvl <= aux_code;
  end
endmodule : antenna_model
`default_nettype wire

// ### sim/tb.sv
// Self-checking bench for the receiver front-end control
`timescale 1ns/1ps
`default_nettype none
module tb;
  import rx_frontend_pkg::*;
  // ==========================================================
  // Stimulus and observed signals
  logic             clk = 1'b0;
  logic             reset = 1'b1;
  logic             ce = 1'b1;
  apb_req_t         req = '0;
  logic             fs = 1'b0;
  logic             fe = 1'b0;
  logic             tone = 1'b0;
  logic             idle1 = 1'b1;
  logic             idle2 = 1'b0;
  logic [2:0]       main_code = 3'h0;
  logic [2:0]       aux_code = 3'h0;
  wire logic        rf1, rf2, pready, pslverr, main_rx, aux_rx, dig_in, def_band, rate_cut, thr_low, frozen;
  wire logic [2:0]  main_lvl, aux_lvl, red;
  wire logic [3:0]  band;
  wire logic [1:0]  dcut;
  wire logic [31:0] prdata;
  int               miscompares = 0;
  int               n_checks = 0;
  localparam logic [11:0] A_CS = {IDX_CHIP_STATUS, 2'b00};
  localparam logic [11:0] A_PR = {IDX_PROTOCOL, 2'b00};
  localparam logic [11:0] A_TU = {IDX_TUNING, 2'b00};
  localparam logic [11:0] A_LV = {IDX_LEVEL, 2'b00};
  logic [7:0] tune_tab [9] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h0c, 8'h08, 8'h04, 8'h02, 8'h00};
  logic [7:0] proto_tab [4] = '{8'h08, 8'h0f, 8'h0a, 8'h03};
  logic [7:0] preset_tab [4] = '{PRESET_A_106, PRESET_B_848, PRESET_F_212, PRESET_OTHER};

  always #10 clk = ~clk;

  antenna_model ant (.clk(clk), .tone(tone), .idle1(idle1), .idle2(idle2), .main_code(main_code),
    .aux_code(aux_code), .rf1(rf1), .rf2(rf2), .main_lvl(main_lvl), .aux_lvl(aux_lvl));
  rx_frontend_ctrl uut (.CLK(clk), .RESET(reset), .CE(ce), .APB_REQ(req), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .FIRST_RF_INPUT(rf1), .SECOND_RF_INPUT(rf2), .MAIN_PATH_LEVEL(main_lvl),
    .AUX_PATH_LEVEL(aux_lvl), .RX_FRAME_START(fs), .RX_FRAME_END(fe), .MAIN_RX(main_rx), .AUX_RX(aux_rx),
    .DIGITIZER_IN(dig_in), .BAND_SELECT(band), .DEFAULT_BAND(def_band), .HIGH_RATE_GAIN_CUT(rate_cut),
    .DIGITIZER_GAIN_CUT(dcut), .AGC_THRESHOLD_LOW(thr_low), .AGC_REDUCTION(red), .AGC_FROZEN(frozen));

  // ==========================================================
  // Compare, report and bus tasks
  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_word
  task automatic chk_pin(input string what, input logic [3:0] exp, input logic [3:0] got);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_pin
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  task automatic frame_start;
    @(posedge clk);
    fs <= 1'b1;
    @(posedge clk);
    fs <= 1'b0;
  endtask : frame_start
  // One APB transfer; for reads d is the expected data, checked only when no error is expected
  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d, input logic err);
    int n;
    @(posedge clk);
    req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: w ? d : 32'h0};
    @(posedge clk);
    req.penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      miscompares++;
      end_sim();
    end
    chk_word("pslverr", {31'h0, err}, {31'h0, pslverr});
    if (!w && !err)
      chk_word("prdata", d, prdata);
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : xfer

  // ==========================================================
  // Main sequence
  initial
  begin
    tick(20);
    reset <= 1'b0;
    tick(8);
    xfer(A_CS, 1'b0, 32'h0, 1'b0);
    xfer(A_TU, 1'b0, 32'h0, 1'b0);
    chk_pin("default_band", 4'h1, {3'h0, def_band});
    chk_pin("route", 4'h6, {1'b0, dig_in, main_rx, aux_rx});
    xfer(A_CS, 1'b1, 32'h8, 1'b0);
    tick(8);
    chk_pin("route", 4'h1, {1'b0, dig_in, main_rx, aux_rx});
    idle1 <= 1'b0;
    idle2 <= 1'b1;
    tick(8);
    chk_pin("route", 4'h6, {1'b0, dig_in, main_rx, aux_rx});
    xfer(A_CS, 1'b1, 32'h0, 1'b0);
    tick(8);
    chk_pin("route", 4'h1, {1'b0, dig_in, main_rx, aux_rx});
    // Clock enable low freezes the routing
    ce <= 1'b0;
    idle1 <= 1'b1;
    tick(10);
    chk_pin("route", 4'h1, {1'b0, dig_in, main_rx, aux_rx});
    ce <= 1'b1;
    tick(8);
    chk_pin("route", 4'h7, {1'b0, dig_in, main_rx, aux_rx});
    // Refused accesses, then a level capture that must survive a write
    xfer(12'h100, 1'b0, 32'h0, 1'b1);
    xfer(12'h002, 1'b1, 32'hff, 1'b1);
    main_code <= 3'h5;
    aux_code <= 3'h2;
    tick(8);
    fe <= 1'b1;
    tick(1);
    fe <= 1'b0;
    tick(2);
    xfer(A_LV, 1'b0, {26'h0, 3'h2, 3'h5}, 1'b0);
    xfer(A_LV, 1'b1, 32'h0, 1'b1);
    xfer(A_LV, 1'b0, {26'h0, 3'h2, 3'h5}, 1'b0);
    foreach (proto_tab[i])
    begin
      xfer(A_PR, 1'b1, {24'h0, proto_tab[i]}, 1'b0);
      xfer(A_TU, 1'b0, {24'h0, preset_tab[i]}, 1'b0);
    end
    foreach (tune_tab[i])
    begin
      xfer(A_TU, 1'b1, {24'h0, tune_tab[i]}, 1'b0);
      tick(2);
      xfer(A_TU, 1'b0, {24'h0, tune_tab[i]}, 1'b0);
      chk_pin("band", tune_tab[i][7:4], band);
      chk_pin("default_band", {3'h0, tune_tab[i][7:4] == 4'h0}, {3'h0, def_band});
      chk_pin("rate_cut", {3'h0, tune_tab[i][4]}, {3'h0, rate_cut});
      chk_pin("digit_cut", {2'h0, tune_tab[i][3:2]}, {2'h0, dcut});
      chk_pin("thr_low", {3'h0, tune_tab[i][1]}, {3'h0, thr_low});
    end
    // Gain control: off, tracking, holding, clearing, threshold
    main_code <= 3'h7;
    frame_start();
    tick(12);
    chk_pin("reduction", 4'h0, {1'b0, red});
    xfer(A_CS, 1'b1, 32'h4, 1'b0);
    tick(14);
    chk_pin("reduction", {1'b0, AGC_MAX}, {1'b0, red});
    main_code <= 3'h0;
    tick(10);
    chk_pin("reduction", {1'b0, AGC_MAX}, {1'b0, red});
    frame_start();
    tick(3);
    chk_pin("reduction", 4'h0, {1'b0, red});
    main_code <= 3'h4;
    tick(12);
    chk_pin("reduction", 4'h0, {1'b0, red});
    xfer(A_TU, 1'b1, 32'h2, 1'b0);
    tick(14);
    chk_pin("reduction", {1'b0, AGC_MAX}, {1'b0, red});
    // Freeze after the subcarrier burst, then override
    main_code <= 3'h0;
    tick(8);
    frame_start();
    tone <= 1'b1;
    tick(100);
    tone <= 1'b0;
    tick(8);
    chk_pin("frozen", 4'h1, {3'h0, frozen});
    main_code <= 3'h7;
    tick(12);
    chk_pin("reduction", 4'h0, {1'b0, red});
    xfer(A_TU, 1'b1, 32'h3, 1'b0);
    tick(14);
    chk_pin("reduction", {1'b0, AGC_MAX}, {1'b0, red});
    chk_pin("frozen", 4'h0, {3'h0, frozen});
    xfer(A_CS, 1'b1, 32'h0, 1'b0);
    tick(5);
    chk_pin("reduction", 4'h0, {1'b0, red});
    end_sim();
  end
endmodule : tb

bind rx_frontend_ctrl rx_frontend_checker chk (.CLK(CLK), .RESET(RESET), .CE(CE), .APB_REQ(APB_REQ),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .MAIN_RX(MAIN_RX), .AUX_RX(AUX_RX), .DIGITIZER_IN(DIGITIZER_IN),
  .BAND_SELECT(BAND_SELECT), .DEFAULT_BAND(DEFAULT_BAND), .HIGH_RATE_GAIN_CUT(HIGH_RATE_GAIN_CUT),
  .RX_FRAME_START(RX_FRAME_START), .AGC_REDUCTION(AGC_REDUCTION), .AGC_FROZEN(AGC_FROZEN));
`default_nettype wire
